// *** shared/qdac_map.svh ***
`ifndef QDAC_MAP_SVH
`define QDAC_MAP_SVH

// Slave address: fixed upper five bits, low two from the straps
`define QDAC_ADDR_HI        5'h03

// Pointer byte fields
`define QDAC_PTR_SEL_LSB    0
`define QDAC_PTR_SEL_MSB    3
`define QDAC_PTR_DOUBLE     4
`define QDAC_PTR_LEFT       5
`define QDAC_PTR_RESET      8'h00

// Control and code word fields
`define QDAC_W_GAIN         15
`define QDAC_W_BUF          14
`define QDAC_W_ZERO_N       13
`define QDAC_W_SLEEP_N      12
`define QDAC_W_CODE_MSB     11
`define QDAC_W_CODE_LSB     0

// Reset values
`define QDAC_CODE_RESET     12'h000
`define QDAC_WORD_IDLE      16'h3000

// Bit and channel counts
`define QDAC_BITS_PER_BYTE  4'h8
`define QDAC_CHANNELS       4

`endif

// *** shared/qdac_pkg.sv ***
package qdac_pkg;

    typedef logic [11:0] qdac_code_t;

    typedef struct packed {
        logic       gain;
        logic       buf_en;
        qdac_code_t code;
    } qdac_chan_s;

    typedef struct packed {
        logic       start;
        logic       stop;
        logic       rise;
        logic       fall;
        logic       sda;
    } qdac_line_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_DATA,
        ST_READ,
        ST_IGNORE
    } qdac_state_e;

endpackage : qdac_pkg

// *** hw/qdac_line_sync.sv ***
`timescale 1ns/1ps
`include "qdac_map.svh"

// Two-flop synchronisers on both bus lines, then edge and condition decode
module qdac_line_sync
    import qdac_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output qdac_line_s       line_out
);

    logic [1:0] scl_meta_q;
    logic [1:0] sda_meta_q;
    logic       scl_last_q;
    logic       sda_last_q;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scl_meta_q <= 2'h3;
            sda_meta_q <= 2'h3;
            scl_last_q <= 1'b1;
            sda_last_q <= 1'b1;
        end else begin
            scl_meta_q <= {scl_meta_q[0], scl_in};
            sda_meta_q <= {sda_meta_q[0], sda_in};
            scl_last_q <= scl_meta_q[1];
            sda_last_q <= sda_meta_q[1];
        end
    end

    wire scl_s = scl_meta_q[1];
    wire sda_s = sda_meta_q[1];

    // SDA moving while SCL stays high marks START or STOP
    assign line_out.start = scl_s & scl_last_q & sda_last_q & ~sda_s;
    assign line_out.stop  = scl_s & scl_last_q & ~sda_last_q & sda_s;
    assign line_out.rise  = scl_s & ~scl_last_q;
    assign line_out.fall  = ~scl_s & scl_last_q;
    assign line_out.sda   = sda_s;

endmodule : qdac_line_sync

// *** hw/qdac_dac_bank.sv ***
`timescale 1ns/1ps
`include "qdac_map.svh"

// Input and DAC register banks for the four channels
module qdac_dac_bank
    import qdac_pkg::*;
(
    input  wire logic                  clock_in,
    input  wire logic                  rst_b_in,
    input  wire logic [3:0]            wr_sel_in,
    input  wire logic                  wr_stb_in,
    input  qdac_chan_s                 wr_chan_in,
    input  wire logic                  clear_all_in,
    input  wire logic                  load_n_in,
    output qdac_chan_s [3:0]           input_regs_out,
    output qdac_chan_s [3:0]           dac_regs_out
);

    qdac_chan_s [3:0] in_q;
    qdac_chan_s [3:0] dac_q;
    logic [3:0]       fresh_q;

    genvar ch;
    generate
        for (ch = 0; ch < `QDAC_CHANNELS; ch++) begin : g_ch
            wire wr_this   = wr_stb_in & wr_sel_in[ch];
            // Only a changed input register is passed on, to spare crosstalk
            wire load_this = ~load_n_in & fresh_q[ch];

            always_ff @(posedge clock_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    in_q[ch]    <= '0;                               // RULE1
                    dac_q[ch]   <= '0;                               // RULE2
                    fresh_q[ch] <= 1'b0;
                end else if (clear_all_in) begin
                    in_q[ch]    <= '0;                               // RULE18
                    dac_q[ch]   <= '0;
                    fresh_q[ch] <= 1'b0;
                end else begin
                    if (wr_this)
                        in_q[ch] <= wr_chan_in;                  // RULE21 RULE23
                    if (load_this)
                        dac_q[ch] <= in_q[ch];                       // RULE24
                    if (wr_this)
                        fresh_q[ch] <= 1'b1;
                    else if (load_this)
                        fresh_q[ch] <= 1'b0;
                end
            end

            stale_hold_a: assert property (
                @(posedge clock_in) disable iff (!rst_b_in)
                (!fresh_q[ch] && !clear_all_in) |=> $stable(dac_q[ch])
            ) else $error("DAC register moved without new input"); // RULE24
        end
    endgenerate

    assign input_regs_out = in_q;
    assign dac_regs_out   = dac_q;

endmodule : qdac_dac_bank

// *** hw/qdac_serial_ctrl.sv ***
`timescale 1ns/1ps
`include "qdac_map.svh"

// How it works
// (RULE1) Registers power up holding zero codes
// (RULE2) Reset gives awake, unbuffered, unity gain, zero
// (RULE3) Address is 00011 plus two strap bits
// (RULE4) Matching address is acknowledged on ninth pulse
// (RULE5) START begins transfer; address byte follows
// (RULE6) Nine pulses per byte; SDA moves low
// (RULE7) Master ends write with STOP
// (RULE8) Master ends read with NACK then STOP
// (RULE9) Write is address, pointer, then data
// (RULE10) Read is pointer write, restart, address read
// (RULE11) Bare address read uses stored pointer
// (RULE12) Pointer bits 3..0 pick D,C,B,A channels
// (RULE13) Master keeps pointer bit 5 zero
// (RULE14) Master keeps pointer bit 4 zero
// (RULE15) Sixteen-bit word: four controls, then code
// (RULE16) Gain bit picks one or two times reference
// (RULE17) Reference drive bit picks buffered input
// (RULE18) Zero-all low clears every register
// (RULE19) Sleep low powers down, outputs float
// (RULE20) Pointer resets zero; no-channel read default
// (RULE21) Several selected channels written together
// (RULE22) Multi-channel read gives only zero-all, sleep
// (RULE23) Completed write loads selected input registers
// (RULE24) DAC registers follow only changed inputs
// (RULE25) Acked readback repeats the same two bytes
// (RULE26) Unmatched address ignored until next START
module qdac_serial_ctrl
    import qdac_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_b_out,
    input  wire logic        addr_strap_low_in,
    input  wire logic        addr_strap_high_in,
    input  wire logic        load_outputs_n_in,
    output logic [3:0]       sleep_n_out,
    output logic [3:0]       gain_out,
    output logic [3:0]       buf_en_out,
    output logic [47:0]      dac_code_out
);

    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    qdac_line_s line;

    qdac_line_sync u_sync (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .line_out (line)
    );

    // Straps come from pins, so they pass two flops as well
    logic [1:0] strap_lo_q;
    logic [1:0] strap_hi_q;
    logic [1:0] load_sync_q;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strap_lo_q  <= 2'h0;
            strap_hi_q  <= 2'h0;
            load_sync_q <= 2'h3;
        end else begin
            strap_lo_q  <= {strap_lo_q[0], addr_strap_low_in};
            strap_hi_q  <= {strap_hi_q[0], addr_strap_high_in};
            load_sync_q <= {load_sync_q[0], load_outputs_n_in};
        end
    end

    // ------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------
    qdac_state_e state_q;
    qdac_state_e state_d;
    logic [3:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic        ack_phase_q;
    logic        data_hi_q;
    logic [7:0]  hi_byte_q;
    logic [7:0]  pointer_q;
    logic        zero_all_n_q;
    logic        sleep_n_q;
    logic        sda_drive_q;
    logic        sda_oe_b_q;
    logic        nack_q;
    logic        rd_hi_q;
    logic        rd_ack_q;

    wire [6:0] own_addr = {`QDAC_ADDR_HI, strap_hi_q[1], strap_lo_q[1]};
    wire byte_done = line.rise & ~ack_phase_q
                   & (bit_cnt_q == `QDAC_BITS_PER_BYTE - 4'h1);
    wire [7:0] byte_in = {shift_q[6:0], line.sda};
    wire addr_hit  = byte_in[7:1] == own_addr;                      // RULE3
    wire [3:0] sel = pointer_q[`QDAC_PTR_SEL_MSB:`QDAC_PTR_SEL_LSB];

    // Readback word from the stored pointer
    qdac_chan_s [3:0] in_regs;
    qdac_chan_s [3:0] dac_regs;
    logic [15:0] rd_word;
    wire one_hot = (sel != 4'h0) && ((sel & (sel - 4'h1)) == 4'h0);
    wire [1:0] sel_idx = sel[0] ? 2'h0 : sel[1] ? 2'h1 :
                         sel[2] ? 2'h2 : 2'h3;
    wire qdac_chan_s rd_chan = in_regs[sel_idx];

    // Multi or no channel reads only the live zero-all and sleep
    assign rd_word = one_hot ?
        {rd_chan.gain, rd_chan.buf_en, zero_all_n_q, sleep_n_q,
         rd_chan.code} :
        {2'h0, zero_all_n_q, sleep_n_q, 12'h000};            // RULE20 RULE22

    // Write completes on the low byte
    wire wr_done = byte_done & (state_q == ST_DATA) & ~data_hi_q;
    wire [15:0] wr_word = {hi_byte_q, byte_in};                     // RULE15
    wire qdac_chan_s wr_chan = '{gain:   wr_word[`QDAC_W_GAIN],     // RULE16
                                 buf_en: wr_word[`QDAC_W_BUF],      // RULE17
                                 code:   wr_word[`QDAC_W_CODE_MSB:0]};
    wire clear_all = wr_done & ~wr_word[`QDAC_W_ZERO_N];            // RULE18

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE, ST_IGNORE: state_d = state_q;
            ST_ADDR:
                if (byte_done)
                    state_d = !addr_hit ? ST_IGNORE :               // RULE26
                              byte_in[0] ? ST_READ : ST_PTR;        // RULE11
            ST_PTR:  if (byte_done) state_d = ST_DATA;              // RULE9
            ST_DATA: state_d = ST_DATA;
            ST_READ: if (nack_q) state_d = ST_IGNORE;               // RULE8
        endcase
        if (line.start)
            state_d = ST_ADDR;                                      // RULE5
        else if (line.stop)
            state_d = ST_IDLE;                                      // RULE7
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Bit counter: eight data pulses then one acknowledge pulse
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bit_cnt_q   <= 4'h0;
            ack_phase_q <= 1'b0;
            shift_q     <= 8'h00;
        end else if (line.start) begin
            bit_cnt_q   <= 4'h0;
            ack_phase_q <= 1'b0;
        end else if (line.rise) begin
            if (ack_phase_q) begin                                  // RULE6
                ack_phase_q <= 1'b0;
                bit_cnt_q   <= 4'h0;
            end else begin
                shift_q     <= byte_in;
                bit_cnt_q   <= bit_cnt_q + 4'h1;
                ack_phase_q <= byte_done;
            end
        end
    end

    // Pointer, data byte pairing and global controls
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pointer_q    <= `QDAC_PTR_RESET;                        // RULE20
            data_hi_q    <= 1'b1;
            hi_byte_q    <= 8'h00;
            zero_all_n_q <= 1'b1;                                   // RULE2
            sleep_n_q    <= 1'b1;
        end else begin
            if (state_q == ST_PTR && byte_done) begin
                pointer_q <= {4'h0, byte_in[3:0]};                  // RULE12
                data_hi_q <= 1'b1;
            end
            if (state_q == ST_DATA && byte_done) begin
                data_hi_q <= ~data_hi_q;
                if (data_hi_q)
                    hi_byte_q <= byte_in;
            end
            if (wr_done) begin
                zero_all_n_q <= wr_word[`QDAC_W_ZERO_N];
                sleep_n_q    <= wr_word[`QDAC_W_SLEEP_N];           // RULE19
            end
        end
    end

    // ------------------------------------------------------------
    // SDA drive: acknowledge and readback bits, changed on SCL low
    // ------------------------------------------------------------
    wire ack_byte = rd_ack_q | (state_q == ST_PTR)
                  | (state_q == ST_DATA);

    // Read address is acknowledged after the state has moved on
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_ack_q <= 1'b0;
        end else if (line.start | line.stop) begin
            rd_ack_q <= 1'b0;
        end else if (state_q == ST_ADDR && byte_done) begin
            rd_ack_q <= addr_hit & byte_in[0];                      // RULE4
        end else if (line.rise && ack_phase_q) begin
            rd_ack_q <= 1'b0;
        end
    end

    wire [3:0] rd_pos = {rd_hi_q, 3'h7} - {1'b0, bit_cnt_q[2:0]};
    wire rd_bit = rd_word[rd_pos];

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sda_drive_q <= 1'b1;
            sda_oe_b_q  <= 1'b1;
            nack_q      <= 1'b0;
            rd_hi_q     <= 1'b1;
        end else if (line.start | line.stop) begin
            sda_oe_b_q  <= 1'b1;
            sda_drive_q <= 1'b1;
            nack_q      <= 1'b0;
            rd_hi_q     <= 1'b1;
        end else begin
            if (line.rise && ack_phase_q && state_q == ST_READ
                && !rd_ack_q) begin
                nack_q  <= line.sda;
                rd_hi_q <= ~rd_hi_q;                                // RULE25
            end
            if (line.fall) begin
                if (ack_phase_q && ack_byte) begin
                    sda_oe_b_q  <= 1'b0;                            // RULE4
                    sda_drive_q <= 1'b0;
                end else if (state_q == ST_READ && !ack_phase_q
                             && !nack_q) begin
                    sda_oe_b_q  <= 1'b0;                            // RULE10
                    sda_drive_q <= rd_bit;
                end else begin
                    sda_oe_b_q  <= 1'b1;
                    sda_drive_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Register banks
    // ------------------------------------------------------------
    qdac_dac_bank u_bank (
        .clock_in       (clock_in),
        .rst_b_in       (rst_b_in),
        .wr_sel_in      (sel),
        .wr_stb_in      (wr_done),
        .wr_chan_in     (wr_chan),
        .clear_all_in   (clear_all),
        .load_n_in      (load_sync_q[1]),
        .input_regs_out (in_regs),
        .dac_regs_out   (dac_regs)
    );

    // Outputs registered; the register bank already holds the codes
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sleep_n_out  <= 4'hF;
            gain_out     <= 4'h0;
            buf_en_out   <= 4'h0;
            dac_code_out <= 48'h0;
        end else begin
            sleep_n_out <= {4{sleep_n_q}};                          // RULE19
            for (int i = 0; i < `QDAC_CHANNELS; i++) begin
                gain_out[i]              <= dac_regs[i].gain;
                buf_en_out[i]            <= dac_regs[i].buf_en;
                dac_code_out[i*12 +: 12] <= dac_regs[i].code;
            end
        end
    end

    assign sda_out      = sda_drive_q;
    assign sda_oe_b_out = sda_oe_b_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ignore_quiet_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        (state_q == ST_IGNORE) |=> sda_oe_b_q
    ) else $error("SDA driven while ignoring the bus");            // RULE26

    ack_drive_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        (line.fall && ack_phase_q && ack_byte && !line.start)
            |=> !sda_oe_b_q && !sda_drive_q
    ) else $error("Acknowledge not driven low");                   // RULE4

    addr_route_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        (state_q == ST_ADDR && byte_done && !line.start && !line.stop
         && !addr_hit) |=> state_q == ST_IGNORE
    ) else $error("Foreign address not ignored");                  // RULE3

    clear_word_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        clear_all |=> in_regs == '0 && dac_regs == '0
    ) else $error("Clear did not zero registers");                 // RULE18

    sleep_out_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        wr_done ##1 1'b1 |=> sleep_n_out[0] == $past(sleep_n_q)
    ) else $error("Sleep output does not follow word");            // RULE19

    ptr_store_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        (state_q == ST_PTR && byte_done)
            |=> pointer_q == {4'h0, $past(byte_in[3:0])}
    ) else $error("Pointer not stored as channel bits");           // RULE12

    idle_word_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        !one_hot |-> rd_word[15:14] == 2'h0 && rd_word[11:0] == 12'h000
    ) else $error("Multi or no channel readback not zero");        // RULE22

    write_load_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        (wr_done && sel[0] && wr_word[`QDAC_W_ZERO_N])
            |=> in_regs[0].code == $past(wr_word[11:0])
    ) else $error("Input register not loaded");                    // RULE23

    sda_hold_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        (!line.fall && !line.start && !line.stop)
            |=> $stable(sda_oe_b_q) && $stable(sda_drive_q)
    ) else $error("SDA moved outside SCL low time");               // RULE6

    read_slot_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        (line.fall && ack_phase_q && state_q == ST_READ && !line.start)
            |=> sda_oe_b_q == !rd_ack_q
    ) else $error("Read acknowledge slot driven wrongly");         // RULE4

endmodule : qdac_serial_ctrl

// *** verification/qdac_i2c_master.sv ***
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Two-wire bus master model
// -----------------------------------------------------------------
// Open drain: sda_rel_out high means released; the wire is pulled up.
// SCL stands still between frames.
module qdac_i2c_master (
    input  wire logic clock_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_rel_out
);
    initial begin
        scl_out     = 1'b1;
        sda_rel_out = 1'b1;
    end

    task automatic q;
        repeat (2) @(negedge clock_in);
    endtask : q

    // Data moves mid-low, sampled mid-high: 400 ns a bit
    task automatic put_bit(input logic b, output logic r);
        sda_rel_out = b;
        q();
        scl_out = 1'b1;
        q();
        r = sda_in;
        q();
        scl_out = 1'b0;
        q();
    endtask : put_bit

    task automatic start;
        sda_rel_out = 1'b1;
        q();
        scl_out = 1'b1;
        q();
        sda_rel_out = 1'b0;
        q();
        scl_out = 1'b0;
        q();
    endtask : start

    task automatic stop;
        sda_rel_out = 1'b0;
        q();
        scl_out = 1'b1;
        q();
        sda_rel_out = 1'b1;
        q();
    endtask : stop

    task automatic byte_w(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(b[i], r);
        put_bit(1'b1, r);
        ack = ~r;
    endtask : byte_w

    task automatic byte_r(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(~ack, r);
    endtask : byte_r
endmodule : qdac_i2c_master

// *** verification/tb.sv ***
`timescale 1ns/1ps

module tb;
    import qdac_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        sh       = 1'b0;
    logic        sl       = 1'b0;
    logic        load_n   = 1'b0;
    wire         scl;
    wire         m_sda;
    logic        sda_o;
    logic        sda_oe_b;
    logic [3:0]  sleep_o;
    logic [3:0]  gain_o;
    logic [3:0]  buf_o;
    logic [47:0] code_o;
    wire         sda_w = m_sda & (sda_oe_b | sda_o);
    int          error_cnt   = 0;
    int          checks_done = 0;
    logic [15:0] in_w[4];
    logic [15:0] dac_w[4];
    logic        sleep_b;
    logic [3:0]  ptr;

    always #25 clock_in = ~clock_in;

    qdac_i2c_master u_qdac_i2c_master (
        .clock_in   (clock_in),
        .sda_in     (sda_w),
        .scl_out    (scl),
        .sda_rel_out(m_sda)
    );

    qdac_serial_ctrl u_qdac_serial_ctrl (
        .clock_in       (clock_in),
        .rst_b_in       (rst_b_in),
        .scl_in         (scl),
        .sda_in         (sda_w),
        .sda_out        (sda_o),
        .sda_oe_b_out   (sda_oe_b),
        .addr_strap_low_in (sl),
        .addr_strap_high_in(sh),
        .load_outputs_n_in (load_n),
        .sleep_n_out    (sleep_o),
        .gain_out       (gain_o),
        .buf_en_out     (buf_o),
        .dac_code_out   (code_o)
    );

    task automatic stop_test;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string nm, input logic [47:0] e,
                         input logic [47:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic settle;
        repeat (8) @(negedge clock_in);
        if (!load_n) dac_w = in_w;
    endtask : settle

    task automatic cmp_all;
        logic [47:0] c;
        logic [3:0]  g;
        logic [3:0]  b;
        for (int i = 0; i < 4; i++) begin
            c[i*12+:12] = dac_w[i][11:0];
            g[i] = dac_w[i][15];
            b[i] = dac_w[i][14];
        end
        check("code", c, code_o);
        check("gain", g, gain_o);
        check("buf", b, buf_o);
        check("sleep", {4{sleep_b}}, sleep_o);
    endtask : cmp_all

    task automatic send(input logic [7:0] b);
        logic a;
        u_qdac_i2c_master.byte_w(b, a);
        check("ack", 1'b1, a);
    endtask : send

    task automatic xfer_w(input logic [7:0] p, input logic [15:0] w);
        u_qdac_i2c_master.start();
        send({5'h03, sh, sl, 1'b0});
        send(p);
        send(w[15:8]);
        send(w[7:0]);
        u_qdac_i2c_master.stop();
        ptr = p[3:0];
        sleep_b = w[12];
        for (int i = 0; i < 4; i++) begin
            if (!w[13]) begin
                in_w[i]  = 16'h0000;
                dac_w[i] = 16'h0000;
            end else if (p[i]) begin
                in_w[i] = w;
            end
        end
        settle();
        cmp_all();
    endtask : xfer_w

    task automatic xfer_r(input logic with_ptr, input logic [3:0] p);
        logic [7:0]  h;
        logic [7:0]  l;
        logic [15:0] e;
        if (with_ptr) begin
            u_qdac_i2c_master.start();
            send({5'h03, sh, sl, 1'b0});
            send({2'($urandom), 2'b00, p});
            ptr = p;
        end
        u_qdac_i2c_master.start();
        send({5'h03, sh, sl, 1'b1});
        e = {3'b001, sleep_b, 12'h000};
        for (int i = 0; i < 4; i++) begin
            if (ptr == 4'(1 << i)) e = {in_w[i][15:14], 1'b1, sleep_b,
                                       in_w[i][11:0]};
        end
        for (int k = 0; k < 2; k++) begin
            u_qdac_i2c_master.byte_r(1'b1, h);
            u_qdac_i2c_master.byte_r(k == 0, l);
            check("readback", e, {h, l});
        end
        u_qdac_i2c_master.stop();
        settle();
    endtask : xfer_r

    initial begin
        #2_000_000;
        error_cnt++;
        stop_test();
    end

    initial begin
        logic a;
        void'($urandom(32'hC1F1));
        for (int i = 0; i < 4; i++) in_w[i] = 16'h0000;
        dac_w   = in_w;
        sleep_b = 1'b1;
        ptr     = 4'h0;
        repeat (5) @(negedge clock_in);
        rst_b_in = 1'b1;
        repeat (6) @(negedge clock_in);
        cmp_all();
        xfer_r(1'b0, 4'h0);
        for (int i = 0; i < 4; i++) begin
            xfer_w({2'($urandom), 2'b00, 4'(1 << i)},
                   16'($urandom) | 16'h3000);
            xfer_r(1'b1, 4'(1 << i));
        end
        xfer_w(8'h05, 16'($urandom) | 16'h3000);
        xfer_w(8'hCF, 16'($urandom) | 16'h3000);
        xfer_r(1'b1, 4'h6);
        load_n = 1'b1;
        xfer_w(8'h02, 16'($urandom) | 16'h3000);
        load_n = 1'b0;
        settle();
        cmp_all();
        xfer_w(8'h08, 16'($urandom) & 16'hEFFF | 16'h2000);
        xfer_r(1'b0, 4'h0);
        for (int s = 0; s < 4; s++) begin
            {sh, sl} = 2'(s);
            repeat (6) @(negedge clock_in);
            u_qdac_i2c_master.start();
            u_qdac_i2c_master.byte_w({5'h03, 2'(s + 1), 1'b0}, a);
            check("nak", 1'b0, a);
            u_qdac_i2c_master.byte_w(8'h0F, a);
            check("nak", 1'b0, a);
            u_qdac_i2c_master.byte_w(8'h00, a);
            u_qdac_i2c_master.stop();
            settle();
            cmp_all();
            xfer_w(8'h0F, 16'($urandom) | 16'h3000);
        end
        xfer_w(8'h01, 16'h1000);
        xfer_w(8'h01, 16'($urandom) | 16'h3000);
        xfer_r(1'b0, 4'h0);
        stop_test();
    end
endmodule : tb
